// ==== sim/rtf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtf_host_model (
	input wire logic clk_sys,
	input wire logic rx_stall,
	output logic rx_valid,
	output logic [7:0] rx_byte
);
	logic [7:0] last;

	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'hFF;
		last = 8'h00;
	end

	// ----------------------------------------
	// byte handshake
	// ----------------------------------------
	// a stalled byte is held until the edge that takes it
	task automatic put(input logic [7:0] b);
		logic s;
		rx_valid <= 1'b1;
		rx_byte <= b;
		// stall is judged as it stands before the edge, not after it
		do begin
			@(negedge clk_sys);
			s = rx_stall;
			@(posedge clk_sys);
		end while (s !== 1'b0);
		last = b;
	endtask : put

	// body runs from the frame type to the last payload byte
	task automatic send_frame(input logic [7:0] body[$], input logic bad);
		logic [7:0] sum;
		logic [15:0] len;
		sum = 8'h00;
		len = 16'(body.size());
		put(rtf_pkg::START_DELIM);
		put(len[15:8]);
		put(len[7:0]);
		foreach (body[i]) begin
			put(body[i]);
			sum = sum + body[i];
		end
		put((rtf_pkg::CSUM_BASE - sum) ^ {7'h00, bad});
		rx_valid <= 1'b0;
		// released line does not keep the last byte
		rx_byte <= ~last;
	endtask : send_frame
endmodule : rtf_host_model
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic rst, rx_valid, rx_stall, reg_wr, reg_rd, desc_valid, pay_valid, pay_ready;
	logic tx_done, tx_ok, status_valid, status_ok, saw_stall;
	logic [7:0] rx_byte, status_type, status_id;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [8:0] pay_data;
	logic [8:0] pay_q[$];
	rtf_pkg::rtf_desc_t desc, got;
	int error_cnt = 0;
	int compares = 0;
	int n_desc = 0;
	int n_stat = 0;

	always #20 clk_sys = ~clk_sys;

	rtf_host_model i_rtf_host_model (.clk_sys(clk_sys), .rx_stall(rx_stall),
		.rx_valid(rx_valid), .rx_byte(rx_byte));
	rtf_framer i_rtf_framer (.clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_valid(desc_valid), .desc(desc),
		.pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data), .tx_done(tx_done),
		.tx_ok(tx_ok), .status_valid(status_valid), .status_type(status_type),
		.status_id(status_id), .status_ok(status_ok), .rx_stall(rx_stall));

	always @(posedge clk_sys) begin
		if (desc_valid === 1'b1) begin
			got = desc;
			n_desc++;
		end
		if (status_valid === 1'b1) n_stat++;
		if (pay_valid === 1'b1 && pay_ready === 1'b1) pay_q.push_back(pay_data);
		if (rx_stall === 1'b1) saw_stall = 1'b1;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic finish_test();
		if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
		@(posedge clk_sys);
	endtask : reg_read

	task automatic frame(input logic [7:0] typ, input logic [7:0] id, input logic [63:0] a64,
		input logic [15:0] a16, input logic [47:0] ext, input logic [7:0] opt, input int n,
		input logic bad, input logic acc);
		logic [7:0] b[$];
		int d0;
		b = {typ, id};
		for (int i = 7; i >= 0; i--) b.push_back(a64[i*8 +: 8]);
		b.push_back(a16[15:8]);
		b.push_back(a16[7:0]);
		if (typ == rtf_pkg::TYPE_EXPLICIT_REQ) begin
			for (int i = 5; i >= 0; i--) b.push_back(ext[i*8 +: 8]);
		end
		b.push_back(8'h01);
		b.push_back(opt & 8'hF3);
		for (int i = 0; i < n; i++) b.push_back(8'hA0 + 8'(i));
		d0 = n_desc;
		pay_q.delete();
		i_rtf_host_model.send_frame(b, bad);
		repeat (4) @(posedge clk_sys);
		check("descriptor count", 64'(n_desc - d0), 64'(acc));
		if (acc) begin
			for (int k = 0; k < 300 && pay_q.size() < n; k++) @(posedge clk_sys);
			check("payload count", 64'(pay_q.size()), 64'(n));
			foreach (pay_q[i]) check("payload byte", pay_q[i], {i == n - 1, 8'hA0 + 8'(i)});
		end
	endtask : frame

	task automatic radio(input logic ok, input logic [7:0] typ, input logic [7:0] id);
		int s0;
		s0 = n_stat;
		tx_done <= 1'b1;
		tx_ok <= ok;
		@(posedge clk_sys);
		tx_done <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check("status count", 64'(n_stat - s0), 64'(id != 8'h00));
		if (id != 8'h00) begin
			check("status type", status_type, typ);
			check("status id", status_id, id);
			check("status ok", status_ok, ok);
		end
	endtask : radio

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		logic [15:0] r;
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pay_ready = 1'b1;
		tx_done = 1'b0;
		tx_ok = 1'b0;
		saw_stall = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		reg_read(4'h0, r);
		check("default options", r, 16'h0000);
		reg_read(4'h1, r);
		check("max payload", r, 16'h0064);
		reg_read(4'hF, r);
		check("unmapped read", r, 16'h0000);
		reg_write(4'h0, 16'h0001);
		frame(8'h10, 8'h52, 64'h0013A20012345678, 16'hFFFE, 48'h0, 8'h00, 6, 1'b0, 1'b1);
		check("no ack", got.no_ack, 1'b1);
		check("no retry", got.no_retry, 1'b1);
		check("addr64", got.addr64, 64'h0013A20012345678);
		check("addr16", got.addr16, 16'hFFFE);
		radio(1'b1, rtf_pkg::TYPE_TX_STATUS, 8'h52);
		frame(8'h10, 8'h00, rtf_pkg::BCAST_ADDR64, 16'hFFFE, 48'h0, 8'h02, 9, 1'b0, 1'b1);
		check("broadcast", got.broadcast, 1'b1);
		check("all pan", got.all_pan, 1'b1);
		check("ack kept", got.no_ack, 1'b0);
		radio(1'b1, rtf_pkg::TYPE_TX_STATUS, 8'h00);
		frame(8'h10, 8'h8D, 64'hFFFFFFFFFFFFFFFF, 16'h1234, 48'h0, 8'h01, 6, 1'b0, 1'b1);
		check("short addr", got.addr16, 16'h1234);
		check("retry off", got.no_retry, 1'b1);
		radio(1'b0, rtf_pkg::TYPE_TX_STATUS, 8'h8D);
		frame(8'h11, 8'h33, 64'h0013A20012345678, 16'hFFFE, 48'hE8E60011C105, 8'h10, 3, 1'b0,
			1'b1);
		check("explicit", got.explicit, 1'b1);
		check("src endpoint", got.src_ep, 8'hE8);
		check("dst endpoint", got.dst_ep, 8'hE6);
		check("cluster", got.cluster, 16'h0011);
		check("profile", got.profile, 16'hC105);
		check("secure", got.secure, 1'b1);
		radio(1'b1, rtf_pkg::TYPE_EXT_TX_STATUS, 8'h33);
		// a secure packet loses four bytes of the limit
		reg_write(4'h1, 16'h0008);
		frame(8'h10, 8'h41, 64'h1, 16'hFFFE, 48'h0, 8'h10, 5, 1'b0, 1'b0);
		frame(8'h10, 8'h42, 64'h1, 16'hFFFE, 48'h0, 8'h10, 4, 1'b0, 1'b1);
		frame(8'h10, 8'h43, 64'h1, 16'hFFFE, 48'h0, 8'h01, 8, 1'b0, 1'b1);
		frame(8'h10, 8'h44, 64'h1, 16'hFFFE, 48'h0, 8'h01, 2, 1'b1, 1'b0);
		reg_read(4'h2, r);
		check("drop count", r[15:8], 8'h02);
		// radio side stalls: a frame larger than the fifo stalls once, then is dropped
		reg_write(4'h1, 16'h0064);
		pay_ready <= 1'b0;
		fork
			frame(8'h10, 8'h45, 64'h1, 16'hFFFE, 48'h0, 8'h01, 24, 1'b0, 1'b0);
			begin
				repeat (80) @(posedge clk_sys);
				pay_ready <= 1'b1;
			end
		join
		check("host stalled", saw_stall, 1'b1);
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		finish_test();
	end
endmodule : tb
`default_nettype wire

// ==== src/rtf_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rp_reg];
	always_ff @(posedge clk_sys) begin
		if (push) mem_reg[wp_reg] <= in_data;
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) wp_reg <= wp_reg + 1'b1;
			if (pop) rp_reg <= rp_reg + 1'b1;
			if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule : rtf_fifo
`default_nettype wire

// ==== src/rtf_framer.sv ====
// What this block does
// R1: option bit 0 sends unicasts without acknowledgment
// R2: option bit 1 addresses all networks
// R3: host keeps reserved option bits zero
// R4: option bit 4 encrypts; max payload minus four
// R5: zero options byte uses stored defaults
// R6: frame id zero suppresses status frame
// R7: nonzero id returns status 0x89, same id
// R8: broadcast address sends to neighbours
// R9: 64-bit addressing uses 16-bit unknown value
// R10: host fills full 64-bit destination
// R11: option bit 0 also disables retries
// R12: accept type 0x11, answer with 0x8B
// R13: explicit request adds endpoints, cluster, profile
// R14: host respects maximum payload count
// R15: short addressing fills 64-bit field ones
// R16: checksum is 0xFF minus byte sum
// R17: length counts bytes between length, checksum
// R18: bad checksum or length drops frame
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rtf_framer (
	input wire logic clk_sys,
	input wire logic rst,
	// host serial byte stream, already in this clock domain
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// packet to radio: descriptor then payload bytes (bit 8 marks last)
	output logic desc_valid,
	output rtf_pkg::rtf_desc_t desc,
	output logic pay_valid,
	input wire logic pay_ready,
	output logic [8:0] pay_data,
	// radio result
	input wire logic tx_done,
	input wire logic tx_ok,
	// status frame request and receive stall to host side
	output logic status_valid,
	output logic [7:0] status_type,
	output logic [7:0] status_id,
	output logic status_ok,
	output logic rx_stall
);
	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	localparam logic [3:0] ADDR_DEFOPT = 4'h0;
	localparam logic [3:0] ADDR_MAXPAY = 4'h1;
	localparam logic [3:0] ADDR_STAT = 4'h2;
	logic [7:0] defopt_reg;
	logic [15:0] maxpay_reg;
	logic [15:0] drops_reg;
	logic [15:0] sent_reg;
	logic [15:0] rdata_reg;
	wire [15:0] rd_mux = (reg_addr == ADDR_DEFOPT) ? {8'h00, defopt_reg} :
		(reg_addr == ADDR_MAXPAY) ? maxpay_reg :
		(reg_addr == ADDR_STAT) ? {drops_reg[7:0], sent_reg[7:0]} : 16'h0000;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			defopt_reg <= rtf_pkg::OPT_RESET;
			maxpay_reg <= rtf_pkg::MAXPAY_RESET;
			rdata_reg <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == ADDR_DEFOPT) defopt_reg <= reg_wdata[7:0];
			if (reg_wr && reg_addr == ADDR_MAXPAY) maxpay_reg <= reg_wdata;
			rdata_reg <= reg_rd ? rd_mux : 16'h0000;
		end
	end
	assign reg_rdata = rdata_reg;

	// ---------------------------------------------
	// frame parser
	// ---------------------------------------------
	rtf_pkg::rtf_state_t st_reg;
	logic [15:0] len_reg;
	logic [15:0] cnt_reg;
	logic [7:0] sum_reg;
	logic [7:0] type_reg;
	logic [4:0] hidx_reg;
	logic [7:0] hdr_reg [20];
	logic bad_reg;

	wire take = rx_valid && !rx_stall;
	wire explicit_w = (type_reg == rtf_pkg::TYPE_EXPLICIT_REQ);
	wire [15:0] hdr_len = explicit_w ? rtf_pkg::HDR_EXPLICIT : rtf_pkg::HDR_PLAIN;
	wire [4:0] last_hidx = hdr_len[4:0] - 5'd1;
	wire [7:0] sum_next = sum_reg + rx_byte;
	wire type_ok = (rx_byte == rtf_pkg::TYPE_TX_REQ) || (rx_byte == rtf_pkg::TYPE_EXPLICIT_REQ); // R12
	wire [7:0] raw_opt = hdr_reg[last_hidx];
	wire [7:0] eff_opt = (raw_opt == 8'h00) ? defopt_reg : raw_opt; // R5
	wire [15:0] pay_cnt = len_reg - 16'd1 - hdr_len; // R17
	wire [15:0] pay_max = (eff_opt & rtf_pkg::OPT_SECURE) != 8'h00 ?
		maxpay_reg - rtf_pkg::SECURE_SHRINK : maxpay_reg; // R4
	wire csum_good = ((rtf_pkg::CSUM_BASE - sum_reg) == rx_byte); // R16
	wire len_short = (len_reg < hdr_len + 16'd1);

	function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
		be16 = {hi, lo};
	endfunction

	// payload goes through the fifo but is committed only after a good checksum;
	// a bad frame sets drop_pend_reg so the drain side discards its fifo words
	logic fin_valid;
	logic fin_ready;
	logic [8:0] fin_data;
	logic fifo_ovf_reg;
	assign fin_valid = take && st_reg == rtf_pkg::RTF_PAY && !fifo_ovf_reg;
	assign fin_data = {1'b0, rx_byte};
	// holding the link while the fifo is full is the back-pressure path;
	// a frame larger than the fifo can never commit, so it is dropped instead
	assign rx_stall = (st_reg == rtf_pkg::RTF_PAY) && !fin_ready && !fifo_ovf_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_reg <= rtf_pkg::RTF_IDLE;
			len_reg <= 16'h0000;
			cnt_reg <= 16'h0000;
			sum_reg <= 8'h00;
			type_reg <= 8'h00;
			hidx_reg <= 5'd0;
			bad_reg <= 1'b0;
		end else if (take) begin
			case (st_reg)
				rtf_pkg::RTF_IDLE: begin
					if (rx_byte == rtf_pkg::START_DELIM) st_reg <= rtf_pkg::RTF_LEN_HI;
				end
				rtf_pkg::RTF_LEN_HI: begin
					len_reg[15:8] <= rx_byte;
					st_reg <= rtf_pkg::RTF_LEN_LO;
				end
				rtf_pkg::RTF_LEN_LO: begin
					len_reg[7:0] <= rx_byte;
					cnt_reg <= 16'h0000;
					sum_reg <= 8'h00;
					st_reg <= rtf_pkg::RTF_TYPE;
				end
				rtf_pkg::RTF_TYPE: begin
					type_reg <= rx_byte;
					sum_reg <= sum_next;
					cnt_reg <= 16'd1;
					hidx_reg <= 5'd0;
					bad_reg <= !type_ok;
					st_reg <= type_ok ? rtf_pkg::RTF_HDR : rtf_pkg::RTF_SKIP;
				end
				rtf_pkg::RTF_HDR: begin
					sum_reg <= sum_next;
					cnt_reg <= cnt_reg + 16'd1;
					hidx_reg <= hidx_reg + 5'd1;
					if (len_short) bad_reg <= 1'b1; // R18
					if (hidx_reg == last_hidx)
						st_reg <= (cnt_reg + 16'd1 == len_reg) ? rtf_pkg::RTF_CSUM : rtf_pkg::RTF_PAY;
				end
				rtf_pkg::RTF_PAY: begin
					sum_reg <= sum_next;
					cnt_reg <= cnt_reg + 16'd1;
					if (cnt_reg + 16'd1 == len_reg) st_reg <= rtf_pkg::RTF_CSUM;
				end
				rtf_pkg::RTF_SKIP: begin
					cnt_reg <= cnt_reg + 16'd1;
					if (cnt_reg + 16'd1 >= len_reg) st_reg <= rtf_pkg::RTF_CSUM;
				end
				rtf_pkg::RTF_CSUM: st_reg <= rtf_pkg::RTF_IDLE;
				default: st_reg <= rtf_pkg::RTF_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (take && st_reg == rtf_pkg::RTF_HDR) hdr_reg[hidx_reg] <= rx_byte;
	end

	// ---------------------------------------------
	// commit on checksum byte
	// ---------------------------------------------
	wire at_csum = take && st_reg == rtf_pkg::RTF_CSUM;
	wire frame_good = at_csum && csum_good && !bad_reg && !len_short &&
		(pay_cnt <= pay_max) && !fifo_ovf_reg; // R18
	wire frame_bad = at_csum && !frame_good;
	logic [15:0] commit_cnt_reg;
	logic drop_pend_reg;
	logic [15:0] drop_cnt_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) fifo_ovf_reg <= 1'b0;
		else if (st_reg == rtf_pkg::RTF_IDLE) fifo_ovf_reg <= 1'b0;
		else if (st_reg == rtf_pkg::RTF_PAY && rx_valid && !fin_ready &&
			commit_cnt_reg == 16'h0000 && !drop_pend_reg) fifo_ovf_reg <= 1'b1; // R18
	end

	rtf_pkg::rtf_desc_t desc_reg;
	logic desc_valid_reg;
	wire [7:0] o = explicit_w ? 8'd6 : 8'd0;
	wire [63:0] a64 = {hdr_reg[1], hdr_reg[2], hdr_reg[3], hdr_reg[4],
		hdr_reg[5], hdr_reg[6], hdr_reg[7], hdr_reg[8]};
	rtf_pkg::rtf_desc_t desc_next;
	always_comb begin
		desc_next = '0;
		desc_next.frame_id = hdr_reg[0];
		desc_next.addr64 = a64; // R10 R15
		desc_next.addr16 = be16(hdr_reg[9], hdr_reg[10]); // R9
		desc_next.explicit = explicit_w; // R13
		desc_next.src_ep = explicit_w ? hdr_reg[11] : 8'h00; // R13
		desc_next.dst_ep = explicit_w ? hdr_reg[12] : 8'h00;
		desc_next.cluster = explicit_w ? be16(hdr_reg[13], hdr_reg[14]) : 16'h0000;
		desc_next.profile = explicit_w ? be16(hdr_reg[15], hdr_reg[16]) : 16'h0000;
		desc_next.radius = hdr_reg[5'd11 + o[4:0]];
		desc_next.broadcast = (a64 == rtf_pkg::BCAST_ADDR64); // R8
		desc_next.no_ack = (eff_opt & rtf_pkg::OPT_NO_ACK) != 8'h00; // R1
		desc_next.no_retry = (eff_opt & rtf_pkg::OPT_NO_ACK) != 8'h00; // R11
		desc_next.all_pan = (eff_opt & rtf_pkg::OPT_ALL_PAN) != 8'h00; // R2
		desc_next.secure = (eff_opt & rtf_pkg::OPT_SECURE) != 8'h00; // R4
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			desc_reg <= '0;
			desc_valid_reg <= 1'b0;
			sent_reg <= 16'h0000;
			drops_reg <= 16'h0000;
		end else begin
			desc_valid_reg <= frame_good;
			if (frame_good) begin
				desc_reg <= desc_next;
				sent_reg <= sent_reg + 16'd1;
			end
			if (frame_bad) drops_reg <= drops_reg + 16'd1;
		end
	end
	assign desc_valid = desc_valid_reg;
	assign desc = desc_reg;

	// fifo drain: payload of good frames forwarded, of bad frames discarded
	logic fout_valid;
	logic [8:0] fout_data;
	logic fout_ready;
	logic [15:0] fwd_cnt_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			commit_cnt_reg <= 16'h0000;
			drop_pend_reg <= 1'b0;
			drop_cnt_reg <= 16'h0000;
		end else begin
			if (frame_good) commit_cnt_reg <= pay_cnt;
			else if (fout_valid && fout_ready && !drop_pend_reg && commit_cnt_reg != 16'h0000)
				commit_cnt_reg <= commit_cnt_reg - 16'd1;
			if (frame_bad && st_reg == rtf_pkg::RTF_CSUM) begin
				drop_pend_reg <= 1'b1;
				drop_cnt_reg <= cnt_reg - 16'd1 - hdr_len;
			end else if (drop_pend_reg && (drop_cnt_reg == 16'h0000 || bad_reg || !fout_valid)) begin
				drop_pend_reg <= 1'b0;
			end else if (drop_pend_reg && fout_valid) begin
				drop_cnt_reg <= drop_cnt_reg - 16'd1;
			end
		end
	end
	assign fwd_cnt_reg = commit_cnt_reg;
	assign fout_ready = drop_pend_reg || (commit_cnt_reg != 16'h0000 && pay_ready);

	logic pay_valid_reg;
	logic [8:0] pay_data_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pay_valid_reg <= 1'b0;
			pay_data_reg <= 9'h000;
		end else begin
			pay_valid_reg <= fout_valid && !drop_pend_reg && commit_cnt_reg != 16'h0000 && pay_ready;
			pay_data_reg <= {commit_cnt_reg == 16'd1, fout_data[7:0]};
		end
	end
	assign pay_valid = pay_valid_reg;
	assign pay_data = pay_data_reg;

	rtf_fifo #(.WIDTH(rtf_pkg::FIFO_WIDTH), .DEPTH(rtf_pkg::FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(fin_valid),
		.in_ready(fin_ready),
		.in_data(fin_data),
		.out_valid(fout_valid),
		.out_ready(fout_ready),
		.out_data(fout_data)
	);

	// ---------------------------------------------
	// status answer
	// ---------------------------------------------
	logic [7:0] pend_id_reg;
	logic pend_exp_reg;
	logic st_valid_reg;
	logic [7:0] st_type_reg;
	logic [7:0] st_id_reg;
	logic st_ok_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_id_reg <= 8'h00;
			pend_exp_reg <= 1'b0;
			st_valid_reg <= 1'b0;
			st_type_reg <= 8'h00;
			st_id_reg <= 8'h00;
			st_ok_reg <= 1'b0;
		end else begin
			if (desc_valid_reg) begin
				pend_id_reg <= desc_reg.frame_id;
				pend_exp_reg <= desc_reg.explicit;
			end
			st_valid_reg <= tx_done && pend_id_reg != 8'h00; // R6 R7
			if (tx_done) begin
				st_type_reg <= pend_exp_reg ? rtf_pkg::TYPE_EXT_TX_STATUS : rtf_pkg::TYPE_TX_STATUS; // R7 R12
				st_id_reg <= pend_id_reg;
				st_ok_reg <= tx_ok;
			end
		end
	end
	assign status_valid = st_valid_reg;
	assign status_type = st_type_reg;
	assign status_id = st_id_reg;
	assign status_ok = st_ok_reg;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	AST_ZERO_ID_SILENT: assert property (@(posedge clk_sys) disable iff (rst)
		tx_done && pend_id_reg == 8'h00 |=> !status_valid) // R6
		else $error("status emitted for zero frame id");
	AST_ID_ECHO: assert property (@(posedge clk_sys) disable iff (rst)
		tx_done && pend_id_reg != 8'h00 |=> status_valid && status_id == $past(pend_id_reg)) // R7
		else $error("status id mismatch");
	AST_EXT_TYPE: assert property (@(posedge clk_sys) disable iff (rst)
		tx_done && pend_exp_reg && pend_id_reg != 8'h00 |=> status_type == 8'h8B) // R12
		else $error("explicit request not answered with extended status");
	AST_BAD_DROP: assert property (@(posedge clk_sys) disable iff (rst)
		at_csum && !csum_good |=> !desc_valid) // R18
		else $error("bad checksum frame was sent");
	AST_DEFAULT_OPT: assert property (@(posedge clk_sys) disable iff (rst)
		frame_good && raw_opt == 8'h00 |=> desc.no_ack == defopt_reg[0]) // R5
		else $error("default options not applied");
	AST_NOACK_RETRY: assert property (@(posedge clk_sys) disable iff (rst)
		desc_valid |-> desc.no_ack == desc.no_retry) // R11
		else $error("ack and retry disagree");
	AST_GOOD_SEND: assert property (@(posedge clk_sys) disable iff (rst)
		frame_good |=> desc_valid ##1 !desc_valid) // R16
		else $error("good frame not forwarded once");
	AST_BCAST: assert property (@(posedge clk_sys) disable iff (rst)
		desc_valid |-> desc.broadcast == (desc.addr64 == 64'h0000_0000_0000_FFFF)) // R8
		else $error("broadcast flag wrong");
endmodule : rtf_framer
`default_nettype wire

// ==== src/rtf_pkg.sv ====
package rtf_pkg;
	localparam logic [7:0] START_DELIM = 8'h7E;
	localparam logic [7:0] TYPE_TX_REQ = 8'h10;
	localparam logic [7:0] TYPE_EXPLICIT_REQ = 8'h11;
	localparam logic [7:0] TYPE_TX_STATUS = 8'h89;
	localparam logic [7:0] TYPE_EXT_TX_STATUS = 8'h8B;
	localparam logic [7:0] CSUM_BASE = 8'hFF;
	localparam logic [7:0] OPT_NO_ACK = 8'h01;
	localparam logic [7:0] OPT_ALL_PAN = 8'h02;
	localparam logic [7:0] OPT_SECURE = 8'h10;
	localparam logic [15:0] SECURE_SHRINK = 16'h0004;
	localparam logic [63:0] BCAST_ADDR64 = 64'h0000_0000_0000_FFFF;
	localparam logic [15:0] UNKNOWN_ADDR16 = 16'hFFFE;
	// header byte counts after the frame type (id, addr64, addr16, radius, options)
	localparam logic [15:0] HDR_PLAIN = 16'h000D;
	localparam logic [15:0] HDR_EXPLICIT = 16'h0013;
	localparam logic [7:0] OPT_RESET = 8'h00;
	localparam logic [15:0] MAXPAY_RESET = 16'h0064;
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [3:0] {
		RTF_IDLE = 4'h0,
		RTF_LEN_HI = 4'h1,
		RTF_LEN_LO = 4'h2,
		RTF_TYPE = 4'h3,
		RTF_HDR = 4'h4,
		RTF_PAY = 4'h5,
		RTF_CSUM = 4'h6,
		RTF_SKIP = 4'h7
	} rtf_state_t;

	typedef struct packed {
		logic [7:0] frame_id;
		logic [63:0] addr64;
		logic [15:0] addr16;
		logic [7:0] radius;
		logic [7:0] src_ep;
		logic [7:0] dst_ep;
		logic [15:0] cluster;
		logic [15:0] profile;
		logic explicit;
		logic no_ack;
		logic no_retry;
		logic all_pan;
		logic secure;
		logic broadcast;
	} rtf_desc_t;
endpackage : rtf_pkg
